// ==== logic/uefc_core.sv ====
/*
  uefc_core: enhanced-feature registers, scratchpad swap, software
  and hardware flow control, special-character and address detect.
  Assumes an APB master, a receiver that offers one character per
  valid, a fifo that reports its fill and a serialiser with ready.
*/
`timescale 1ns/1ps
module uefc_core
  import uefc_pkg::*;
#(
  parameter int         CNT_W    = 8,     // fifo count width
  parameter logic [7:0] RTS_HYST = 8'h04  // hysteresis around trigger
)(
  input  wire logic        pclk,          // bus clock
  input  wire logic        presetn,       // async reset, low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // unmapped access
  input  wire logic [CNT_W-1:0] rx_count, // rx fifo fill
  input  wire logic [CNT_W-1:0] tx_count, // tx fifo fill
  input  wire uefc_char_t  rx_in,         // received character
  output uefc_char_t       rx_store,      // character to rx fifo
  input  wire uefc_char_t  tx_in,         // data from tx fifo
  output logic             tx_in_ready,   // tx fifo pop
  output uefc_char_t       tx_out,        // character to serialiser
  input  wire logic        tx_out_ready,  // serialiser takes it
  input  wire logic        cts_n,         // clear to send, low
  output logic             rts_n,         // request to send, low
  output logic             rx_trig_hit,   // auto rts trigger flag
  output uefc_cfg_t        cfg            // settings to the uart
);

  ////////////////////////////////////////////////////////////////
  // parameter checks
  if (CNT_W < 1 || CNT_W > 8)
    $error("uefc_core: CNT_W must be 1..8");
  if (RTS_HYST == 8'h00)
    $error("uefc_core: RTS_HYST must be nonzero");

  ////////////////////////////////////////////////////////////////
  // helpers

  // protected bits take new data only when unlocked
  function automatic logic [7:0] guard(input logic [7:0] old,
                                       input logic [7:0] nw,
                                       input logic [7:0] m,
                                       input logic       en);
    guard = (nw & ~m) | ((en ? nw : old) & m);
  endfunction : guard

  // count at or above trigger plus offset, nine bits wide
  function automatic logic at_or_above(input logic [CNT_W-1:0] c,
                                       input logic [7:0] t,
                                       input logic [7:0] h);
    at_or_above = 9'(c) >= (9'(t) + 9'(h));
  endfunction : at_or_above

  ////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] scratchpad;
  logic [7:0] feature_control;
  logic [7:0] enhanced_feature_control;
  logic [7:0] resume_char_first;
  logic [7:0] resume_char_second;
  logic [7:0] pause_char_first;
  logic [7:0] pause_char_second;
  logic [7:0] rx_trigger;
  logic [7:0] tx_trigger;
  logic [7:0] interrupt_enable;
  logic [1:0] status_flags;
  logic [7:0] fifo_control;
  logic [7:0] modem_control;
  logic [7:0] fractional_divisor;
  logic [7:0] enhanced_mode_a;
  logic [7:0] enhanced_mode_b;
  logic [7:0] enhanced_mode_select;
  logic       multidrop_en;

  // flow and detect state
  logic       remote_paused;
  logic       sent_pause;
  logic       rts_hold;
  logic       addr_selected;
  logic       seq_on;
  logic       seq_off;
  logic       pair_pause;
  logic       set_spec;
  logic       set_pause;

  typedef enum logic [0:0] {TX_IDLE, TX_PAIR} uefc_tx_t;
  uefc_tx_t   tx_state;

  logic       wr;
  logic       setup_rd;
  logic       unlocked;
  logic [7:0] wbyte;
  logic       swap;
  logic       mapped;

  assign wr       = psel & penable & pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wbyte    = pwdata[7:0];
  assign unlocked = enhanced_feature_control[EF_ENH];
  assign swap     = feature_control[FC_SWAP];

  ////////////////////////////////////////////////////////////////
  // plain and swapped scratchpad location
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scratchpad           <= RST_SCRATCH;
      enhanced_mode_select <= RST_ZERO;
    end
    else if (wr && paddr == OFF_SCRATCH)
    begin
      if (!swap)
        scratchpad <= wbyte;
      else
        enhanced_mode_select <= wbyte;
    end
  end

  // feature control, characters and trigger levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      feature_control    <= RST_ZERO;
      resume_char_first  <= RST_ZERO;
      resume_char_second <= RST_ZERO;
      pause_char_first   <= RST_ZERO;
      pause_char_second  <= RST_ZERO;
      rx_trigger         <= RST_TRIGGER;
      tx_trigger         <= RST_TRIGGER;
      multidrop_en       <= 1'b0;
    end
    else if (wr)
    begin
      unique case (paddr)
        OFF_FEATURE: feature_control    <= wbyte;
        OFF_RES1:    resume_char_first  <= wbyte;
        OFF_RES2:    resume_char_second <= wbyte;
        OFF_PAU1:    pause_char_first   <= wbyte;
        OFF_PAU2:    pause_char_second  <= wbyte;
        OFF_LINK:    multidrop_en       <= wbyte[LK_MDROP];
        OFF_TRIGGER:
        begin
          if (feature_control[FC_TXSEL])
            tx_trigger <= wbyte;
          else
            rx_trigger <= wbyte;
        end
        default: ;
      endcase
    end
  end

  // write-protected enhanced settings; reset restores legacy mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enhanced_feature_control <= RST_ZERO;
      interrupt_enable         <= RST_ZERO;
      fifo_control             <= RST_ZERO;
      modem_control            <= RST_ZERO;
      fractional_divisor       <= RST_ZERO;
      enhanced_mode_a          <= RST_ZERO;
      enhanced_mode_b          <= RST_ZERO;
    end
    else if (wr)
    begin
      unique case (paddr)
        OFF_EFC:
          enhanced_feature_control <= guard(enhanced_feature_control,
                                            wbyte, MASK_EFC, unlocked);
        OFF_INT_EN:   interrupt_enable <= guard(interrupt_enable, wbyte, MASK_IE, unlocked);
        OFF_FIFO_CTL: fifo_control <= guard(fifo_control, wbyte, MASK_FCTL, unlocked);
        OFF_MODEM:    modem_control <= guard(modem_control, wbyte, MASK_MC, unlocked);
        OFF_FRAC:     fractional_divisor <= guard(fractional_divisor, wbyte, MASK_ALL, unlocked);
        OFF_MODE_A:   enhanced_mode_a <= guard(enhanced_mode_a, wbyte, MASK_ALL, unlocked);
        OFF_MODE_B:   enhanced_mode_b <= guard(enhanced_mode_b, wbyte, MASK_ALL, unlocked);
        default: ;
      endcase
    end
  end

  // sticky status bits: a set in the clearing cycle wins
  logic [1:0] clr_flags;
  assign clr_flags = (wr && paddr == OFF_INT_STAT && unlocked) ?
                     wbyte[IS_PAUSE:IS_SPEC] : 2'b00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_flags <= 2'b00;
    else
      status_flags <= (status_flags & ~clr_flags) | {set_pause, set_spec};
  end

  ////////////////////////////////////////////////////////////////
  logic [7:0] sel_count;
  assign sel_count = feature_control[FC_TXSEL] ? 8'(tx_count)
                                               : 8'(rx_count);

  // read mux; unmapped locations read zero and flag an error
  logic [7:0] rd_byte;
  always_comb
  begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      OFF_SCRATCH:  rd_byte = swap ? sel_count : scratchpad;
      OFF_FEATURE:  rd_byte = feature_control;
      OFF_EFC:      rd_byte = enhanced_feature_control;
      OFF_RES1:     rd_byte = resume_char_first;
      OFF_RES2:     rd_byte = resume_char_second;
      OFF_PAU1:     rd_byte = pause_char_first;
      OFF_PAU2:     rd_byte = pause_char_second;
      OFF_INT_EN:   rd_byte = interrupt_enable;
      OFF_INT_STAT: rd_byte = {2'b00, status_flags, 4'h0};
      OFF_FIFO_CTL: rd_byte = fifo_control;
      OFF_MODEM:    rd_byte = modem_control;
      OFF_FRAC:     rd_byte = fractional_divisor;
      OFF_MODE_A:   rd_byte = enhanced_mode_a;
      OFF_MODE_B:   rd_byte = enhanced_mode_b;
      OFF_LINK:     rd_byte = {addr_selected, remote_paused, sent_pause, rts_hold, 3'b000, multidrop_en};
      OFF_TRIGGER:  rd_byte = 8'h00; // trigger is write-only
      default:      mapped  = 1'b0;
    endcase
  end

  // captured in the setup cycle, so the access needs no wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_rd)
      prdata <= {24'h00_0000, rd_byte};
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  ////////////////////////////////////////////////////////////////
  // receive compare; a field of 11 defers to the tx field
  logic [1:0] rx_mode;
  logic [1:0] tx_mode;
  logic [7:0] c;
  logic       m_first;
  logic       m_second;
  logic       m_either;
  logic       m_seq;
  logic       on_hit;
  logic       off_hit;
  logic       spec_hit;
  logic       is_addr;
  logic       take;

  assign rx_mode  = enhanced_feature_control[1:0];
  assign tx_mode  = enhanced_feature_control[3:2];
  assign c        = rx_in.data; // bit 0 is the first bit on the wire
  assign m_first  = rx_mode == FLOW_FIRST;
  assign m_second = rx_mode == FLOW_SECOND;
  assign m_either = rx_mode == FLOW_BOTH &&
                    (tx_mode == FLOW_FIRST || tx_mode == FLOW_SECOND);
  assign m_seq    = rx_mode == FLOW_BOTH &&
                    (tx_mode == FLOW_BOTH || tx_mode == FLOW_NONE);

  assign is_addr = multidrop_en & rx_in.addr;
  assign take    = rx_in.valid & ~is_addr & (~multidrop_en | addr_selected);

  always_comb
  begin
    on_hit = (m_first && c == resume_char_first) ||
             (m_second && c == resume_char_second) ||
             (m_either && (c == resume_char_first || c == resume_char_second)) ||
             (m_seq && seq_on && c == resume_char_second);
    off_hit = (m_first && c == pause_char_first) ||
              (m_second && c == pause_char_second) ||
              (m_either && (c == pause_char_first || c == pause_char_second)) ||
              (m_seq && seq_off && c == pause_char_second);
    spec_hit = enhanced_feature_control[EF_SPEC] &&
               (c == pause_char_second);
  end

  // flag updates for the status register
  assign set_pause = take & off_hit;
  assign set_spec  = take & spec_hit &
                     (~off_hit | interrupt_enable[IE_SPEC]);

  // flow state, sequence tracking and address selection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      remote_paused <= 1'b0;
      seq_on        <= 1'b0;
      seq_off       <= 1'b0;
      addr_selected <= 1'b0;
    end
    else
    begin
      if (rx_in.valid && is_addr)
        addr_selected <= c == pause_char_second;
      if (rx_mode == FLOW_NONE)
        remote_paused <= 1'b0;
      else if (take && off_hit)
        remote_paused <= 1'b1;
      else if (take && on_hit)
        remote_paused <= 1'b0;
      if (take)
      begin
        seq_on  <= m_seq && c == resume_char_first;
        seq_off <= m_seq && c == pause_char_first;
      end
    end
  end

  // store path: matched flow characters, in sequence mode only the second of the pair, never reach the fifo
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_store <= '0;
    else
    begin
      rx_store.valid <= take & ~on_hit & ~off_hit;
      rx_store.addr  <= 1'b0;
      rx_store.data  <= c;
    end
  end

  ////////////////////////////////////////////////////////////////
  // auto rts with hysteresis around the rx trigger
  logic upper;
  logic lower;
  logic at_trig;

  assign at_trig = at_or_above(rx_count, rx_trigger, 8'h00);
  assign upper   = at_or_above(rx_count, rx_trigger, RTS_HYST);
  assign lower   = ~at_or_above(rx_count, rx_trigger - RTS_HYST, 8'h00) &
                   (rx_trigger >= RTS_HYST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rts_hold <= 1'b0;
    else if (!enhanced_feature_control[EF_ARTS])
      rts_hold <= 1'b0;
    else if (upper)
      rts_hold <= 1'b1;
    else if (lower)
      rts_hold <= 1'b0;
  end

  // rts is a plain output unless auto mode and software asserted it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rts_n       <= 1'b1;
      rx_trig_hit <= 1'b0;
    end
    else
    begin
      rts_n       <= ~(modem_control[MC_RTS] & ~rts_hold);
      rx_trig_hit <= enhanced_feature_control[EF_ARTS] & at_trig;
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmit: flow characters take priority over fifo data
  logic out_free;
  logic cts_ok;
  logic flow_req;
  logic tx_flow;
  logic load_flow;

  assign out_free = ~tx_out.valid | tx_out_ready;
  assign cts_ok   = ~(enhanced_feature_control[EF_ACTS] & cts_n);
  assign tx_flow  = tx_mode != FLOW_NONE;
  assign flow_req = tx_flow & (sent_pause ? lower : at_trig);
  assign load_flow = out_free & cts_ok & tx_state == TX_IDLE & flow_req;
  assign tx_in_ready = out_free & cts_ok & tx_state == TX_IDLE &
                       ~flow_req & ~remote_paused;

  // pick the character for the start of a flow sequence
  logic [7:0] flow_first;
  assign flow_first = (tx_mode == FLOW_SECOND) ?
                      (sent_pause ? resume_char_second : pause_char_second) :
                      (sent_pause ? resume_char_first : pause_char_first);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state   <= TX_IDLE;
      sent_pause <= 1'b0;
      pair_pause <= 1'b0;
    end
    else if (!tx_flow)
    begin
      tx_state   <= TX_IDLE;
      sent_pause <= 1'b0;
    end
    else
    begin
      unique case (tx_state)
        TX_IDLE:
        begin
          if (load_flow)
          begin
            sent_pause <= ~sent_pause;
            pair_pause <= ~sent_pause;
            if (tx_mode == FLOW_BOTH)
              tx_state <= TX_PAIR;
          end
        end
        TX_PAIR:
        begin
          if (out_free && cts_ok)
            tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // registered character to the serialiser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_out <= '0;
    else if (out_free)
    begin
      tx_out.addr <= 1'b0;
      if (tx_state == TX_PAIR && tx_flow && cts_ok)
      begin
        tx_out.valid <= 1'b1;
        tx_out.data  <= pair_pause ? pause_char_second
                                   : resume_char_second;
      end
      else if (load_flow && tx_flow)
      begin
        tx_out.valid <= 1'b1;
        tx_out.data  <= flow_first;
      end
      else if (tx_in_ready && tx_in.valid)
      begin
        tx_out.valid <= 1'b1;
        tx_out.addr  <= tx_in.addr;
        tx_out.data  <= tx_in.data;
      end
      else
        tx_out.valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // settings to the rest of the uart
  assign cfg = {interrupt_enable, fifo_control, modem_control, fractional_divisor,
                enhanced_mode_a, enhanced_mode_b, enhanced_mode_select, tx_trigger};

endmodule : uefc_core

// ==== logic/uefc_pkg.sv ====
/*
  uefc_pkg: offsets, field positions, reset values and carriers
  for the enhanced-feature and flow-control block.
  Assumes a 32-bit APB with byte addresses, one register per word.
*/
package uefc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_SCRATCH  = 8'h00;
  localparam logic [7:0] OFF_FEATURE  = 8'h04;
  localparam logic [7:0] OFF_EFC      = 8'h08;
  localparam logic [7:0] OFF_RES1     = 8'h0C;
  localparam logic [7:0] OFF_RES2     = 8'h10;
  localparam logic [7:0] OFF_PAU1     = 8'h14;
  localparam logic [7:0] OFF_PAU2     = 8'h18;
  localparam logic [7:0] OFF_TRIGGER  = 8'h1C;
  localparam logic [7:0] OFF_INT_EN   = 8'h20;
  localparam logic [7:0] OFF_INT_STAT = 8'h24;
  localparam logic [7:0] OFF_FIFO_CTL = 8'h28;
  localparam logic [7:0] OFF_MODEM    = 8'h2C;
  localparam logic [7:0] OFF_FRAC     = 8'h30;
  localparam logic [7:0] OFF_MODE_A   = 8'h34;
  localparam logic [7:0] OFF_MODE_B   = 8'h38;
  localparam logic [7:0] OFF_LINK     = 8'h3C;

  // feature_control fields
  localparam int FC_SWAP  = 6;
  localparam int FC_TXSEL = 7;
  // enhanced_feature_control fields
  localparam int EF_ENH  = 4;
  localparam int EF_SPEC = 5;
  localparam int EF_ARTS = 6;
  localparam int EF_ACTS = 7;
  // other field positions
  localparam int IE_SPEC   = 5;
  localparam int IS_SPEC   = 4;
  localparam int IS_PAUSE  = 5;
  localparam int MC_RTS    = 1;
  localparam int LK_MDROP  = 0;

  // protected bit masks
  localparam logic [7:0] MASK_EFC  = 8'h0F;
  localparam logic [7:0] MASK_IE   = 8'hF0;
  localparam logic [7:0] MASK_IS   = 8'h30;
  localparam logic [7:0] MASK_FCTL = 8'h38;
  localparam logic [7:0] MASK_MC   = 8'hE0;
  localparam logic [7:0] MASK_ALL  = 8'hFF;

  // flow-control field codes
  localparam logic [1:0] FLOW_NONE   = 2'b00;
  localparam logic [1:0] FLOW_FIRST  = 2'b10;
  localparam logic [1:0] FLOW_SECOND = 2'b01;
  localparam logic [1:0] FLOW_BOTH   = 2'b11;

  // reset values
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'hFF;
  localparam logic [7:0] RST_TRIGGER = 8'h01;

  // one character on a stream, with the multidrop address bit
  typedef struct packed {
    logic       valid;
    logic       addr;
    logic [7:0] data;
  } uefc_char_t;

  // configuration handed to the rest of the uart
  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic [7:0] fifo_control;
    logic [7:0] modem_control;
    logic [7:0] fractional_divisor;
    logic [7:0] enhanced_mode_a;
    logic [7:0] enhanced_mode_b;
    logic [7:0] enhanced_mode_select;
    logic [7:0] tx_trigger;
  } uefc_cfg_t;

endpackage : uefc_pkg

// ==== verification/uefc_core_checker.sv ====
/*
  uefc_core_checker: port-level properties of uefc_core.
  Assumes one clock domain and binding to the design top.
*/
`timescale 1ns/1ps
module uefc_core_checker
  import uefc_pkg::*;
(
  input wire logic       pclk,         // bus clock
  input wire logic       presetn,      // async reset, low
  input wire logic       psel,         // apb select
  input wire logic       penable,      // apb access
  input wire logic       pwrite,       // apb direction
  input wire uefc_char_t rx_in,        // received char
  input wire uefc_char_t rx_store,     // char to fifo
  input wire uefc_char_t tx_in,        // tx fifo data
  input wire logic       tx_in_ready,  // tx fifo pop
  input wire uefc_char_t tx_out,       // char to serialiser
  input wire logic       tx_out_ready, // serialiser ready
  input wire logic       rts_n,        // request to send
  input wire uefc_cfg_t  cfg           // settings
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////
  a_store_follow: assert property (rx_store.valid |-> $past(rx_in.valid)
    && rx_store.data == $past(rx_in.data)) else $error("stored char not the received one");
  a_store_noaddr: assert property (rx_store.valid |-> !rx_store.addr)
    else $error("stored char carries address flag");
  a_tx_holds: assert property (tx_out.valid && !tx_out_ready |=>
    tx_out.valid && $stable(tx_out.data)) else $error("tx char dropped before taken");
  a_tx_loads: assert property (tx_in_ready && tx_in.valid |=>
    tx_out.valid && tx_out.data == $past(tx_in.data)) else $error("popped byte not sent");
  a_rts_manual: assert property (!cfg.modem_control[MC_RTS] [*2] |-> rts_n)
    else $error("rts asserted without modem request");
  a_reset_clear: assert property ($rose(presetn) |-> cfg.fractional_divisor == 8'h00
    && cfg.enhanced_mode_a == 8'h00 && cfg.interrupt_enable == 8'h00) else $error("reset left bits");
  a_lock_frac: assert property ($changed(cfg.fractional_divisor) |->
    $past(psel && penable && pwrite)) else $error("divisor changed without write");
  a_lock_ie: assert property ($changed(cfg.interrupt_enable[7:4]) |->
    $past(psel && penable && pwrite)) else $error("int enable changed without write");
  c_store: cover property (rx_store.valid);
  c_sent: cover property (tx_out.valid && tx_out_ready);
  c_rts: cover property (!rts_n ##1 rts_n);
endmodule : uefc_core_checker
bind uefc_core uefc_core_checker i_uefc_core_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .rx_in(rx_in), .rx_store(rx_store), .tx_in(tx_in), .tx_in_ready(tx_in_ready),
  .tx_out(tx_out), .tx_out_ready(tx_out_ready), .rts_n(rts_n), .cfg(cfg));

// ==== verification/uefc_core_tb.sv ====
/*
  uefc_core_tb: self-checking bench for uefc_core.
  Assumes zero-wait apb and the peer model beside it.
*/
`timescale 1ns/1ps
module uefc_core_tb
  import uefc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hold;
  logic [7:0] paddr, rx_count, tx_count, stq[$];
  logic [31:0] pwdata, prdata;
  uefc_char_t rx_in, rx_store, tx_in, tx_out;
  logic tx_in_ready, tx_out_ready, cts_n, rts_n, rx_trig_hit;
  uefc_cfg_t cfg;
  int num_errors = 0;
  int samples_checked = 0;
  uefc_core i_uefc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_count(rx_count), .tx_count(tx_count), .rx_in(rx_in),
    .rx_store(rx_store), .tx_in(tx_in), .tx_in_ready(tx_in_ready), .tx_out(tx_out),
    .tx_out_ready(tx_out_ready), .cts_n(cts_n), .rts_n(rts_n), .rx_trig_hit(rx_trig_hit), .cfg(cfg));
  uefc_peer i_uefc_peer (.pclk(pclk), .hold(hold), .tx_out(tx_out), .rx_in(rx_in),
    .cts_n(cts_n), .tx_out_ready(tx_out_ready));
  //////////////////////////////
  task end_sim;
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // one apb transfer, then an idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n == 20) chk("pready", 1'b1, 1'b0);
    if (n == 20) end_sim();
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 8'h00, r);
    chk($sformatf("reg %h", a), {24'h00_0000, e}, r);
  endtask : rc
  task automatic wait_tx(input int k);
    int n;
    for (n = 0; n < 80 && i_uefc_peer.got.size() < k; n++)
      @(posedge pclk);
    chk("tx count", k, i_uefc_peer.got.size());
    if (n == 80) end_sim();
  endtask : wait_tx
  task automatic fill(input logic [7:0] v, input logic e, input string n);
    rx_count <= v;
    repeat (3) @(posedge pclk);
    chk(n, e, rts_n);
  endtask : fill
  //////////////////////////////
  task t_lock;
    chk("tx trig", 8'h01, cfg.tx_trigger);
    rc(OFF_EFC, 8'h00);
    wr(OFF_FRAC, 8'h55);
    chk("frac locked", 8'h00, cfg.fractional_divisor);
    wr(OFF_EFC, 8'h10);
    wr(OFF_EFC, 8'h1F);
    rc(OFF_EFC, 8'h1F);
    wr(OFF_EFC, 8'h10);
    wr(OFF_FRAC, 8'h55);
    wr(OFF_EFC, 8'h00);
    wr(OFF_FRAC, 8'hAA);
    chk("frac held", 8'h55, cfg.fractional_divisor);
    wr(OFF_EFC, 8'h10);
  endtask : t_lock
  task t_swap;
    rc(OFF_SCRATCH, 8'hFF);
    wr(OFF_SCRATCH, 8'h5A);
    wr(OFF_FEATURE, 8'h40);
    wr(OFF_SCRATCH, 8'h33);
    chk("mode sel", 8'h33, cfg.enhanced_mode_select);
    rc(OFF_SCRATCH, 8'h07);
    wr(OFF_FEATURE, 8'hC0);
    rc(OFF_SCRATCH, 8'h09);
    wr(OFF_TRIGGER, 8'h20);
    chk("tx trig", 8'h20, cfg.tx_trigger);
    wr(OFF_FEATURE, 8'h00);
    wr(OFF_TRIGGER, 8'h08);
    rc(OFF_SCRATCH, 8'h5A);
    rc(8'h40, 8'h00);
    chk("slverr", 1'b1, err);
  endtask : t_swap
  // upper level is trigger plus four, lower trigger minus four
  task t_rts;
    wr(OFF_MODEM, 8'h02);
    wr(OFF_EFC, 8'h50);
    fill(8'h08, 1'b0, "rts at trig");
    chk("trig hit", 1'b1, rx_trig_hit);
    fill(8'h0C, 1'b1, "rts upper");
    fill(8'h04, 1'b1, "rts hyst");
    fill(8'h03, 1'b0, "rts lower");
    wr(OFF_MODEM, 8'h00);
    fill(8'h00, 1'b1, "rts manual");
  endtask : t_rts
  task t_cts;
    wr(OFF_EFC, 8'h90);
    hold <= 1'b1;
    i_uefc_peer.got.delete();
    repeat (2) @(posedge pclk);
    tx_in <= '{1'b1, 1'b0, 8'h61};
    repeat (12) @(posedge pclk);
    chk("cts held", 0, i_uefc_peer.got.size());
    hold <= 1'b0;
    wait_tx(1);
    chk("cts data", 8'h61, i_uefc_peer.got[0]);
  endtask : t_cts
  // each tx flow code (first, second, both): pause on fill, resume on drain
  task t_pair;
    logic [31:0] s;
    logic [31:0] e[3] = '{32'h0000_A111, 32'h0000_A222, 32'hA1A2_1122};
    logic [1:0] f[3] = '{FLOW_FIRST, FLOW_SECOND, FLOW_BOTH};
    wr(OFF_EFC, 8'h10);
    wr(OFF_RES1, 8'h11);
    wr(OFF_RES2, 8'h22);
    wr(OFF_PAU1, 8'hA1);
    wr(OFF_PAU2, 8'hA2);
    i_uefc_peer.slow <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      i_uefc_peer.got.delete();
      wr(OFF_EFC, {4'h1, f[i], 2'b00});
      rx_count <= 8'h08;
      wait_tx(i / 2 + 1);
      rx_count <= 8'h00;
      wait_tx(2 * (i / 2 + 1));
      s = '0;
      foreach (i_uefc_peer.got[j]) s = {s[23:0], i_uefc_peer.got[j]};
      chk("flow chars", e[i], s);
      wr(OFF_EFC, 8'h10);
    end
  endtask : t_pair
  task t_spec;
    logic [31:0] r;
    stq.delete();
    wr(OFF_PAU2, 8'h13);
    wr(OFF_EFC, 8'h30);
    i_uefc_peer.send(8'h12);
    xfer(1'b0, OFF_INT_STAT, 8'h00, r);
    chk("near miss", 1'b0, r[IS_SPEC]);
    i_uefc_peer.send(8'h13);
    xfer(1'b0, OFF_INT_STAT, 8'h00, r);
    chk("spec flag", 1'b1, r[IS_SPEC]);
    chk("spec fifo", 16'h1213, {stq[0], stq[1]});
    wr(OFF_INT_STAT, 8'h30);
    wr(OFF_INT_EN, 8'h20);
    wr(OFF_EFC, 8'h10);
    wr(OFF_EFC, 8'h31);
    i_uefc_peer.send(8'h13);
    xfer(1'b0, OFF_INT_STAT, 8'h00, r);
    chk("pause flags", 2'b11, r[5:4]);
    chk("pause dropped", 2, stq.size());
  endtask : t_spec
  //////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // record stored chars, drop tx valid once popped
  always @(posedge pclk)
  begin
    if (rx_store.valid === 1'b1) stq.push_back(rx_store.data);
    if (tx_in.valid && tx_in_ready === 1'b1) tx_in.valid <= 1'b0;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, hold, err} = '0;
    paddr = 8'h00;
    pwdata = '0;
    rx_count = 8'h07;
    tx_count = 8'h09;
    tx_in = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_lock();
    t_swap();
    t_rts();
    t_cts();
    t_pair();
    t_spec();
    end_sim();
  end
endmodule : uefc_core_tb

// ==== verification/uefc_peer.sv ====
/*
  uefc_peer: remote serial peer of the flow-control block.
  Assumes one clock shared with the device side.
*/
`timescale 1ns/1ps
module uefc_peer
  import uefc_pkg::*;
(
  input  wire logic       pclk,         // device clock
  input  wire logic       hold,         // peer wants a pause
  input  wire uefc_char_t tx_out,       // characters from device
  output uefc_char_t      rx_in,        // characters to device
  output logic            cts_n,        // clear to send, low
  output logic            tx_out_ready  // peer takes a character
);
  logic [7:0] got[$];
  logic       slow = 1'b0;
  initial
  begin
    rx_in = '0;
    cts_n = 1'b0;
    tx_out_ready = 1'b0;
  end
  // slow peer takes every other cycle, so valid must hold
  always @(posedge pclk)
  begin
    cts_n <= hold;
    tx_out_ready <= slow ? ~tx_out_ready : 1'b1;
    if (tx_out.valid === 1'b1 && tx_out_ready)
      got.push_back(tx_out.data);
  end
  // idle data flips so a stale byte never looks valid
  task automatic send(input logic [7:0] d);
    rx_in <= '{1'b1, 1'b0, d};
    @(posedge pclk);
    rx_in <= '{1'b0, 1'b0, ~d};
    @(posedge pclk);
  endtask : send
endmodule : uefc_peer
